// ===== logic/palette_pkg.sv
// Purpose: Shared constants and carriers for the palette pixel lookup port
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses
// Notes:   Level steps are in DAC code units on a 10-bit output scale
package palette_pkg;

    // ==========================================================
    // Register map (byte offsets)
    localparam logic [7:0] REG_MASK = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;

    // ==========================================================
    // Fields and reset values
    localparam int ADDR_OVL_BIT = 8;
    localparam int CTRL_EIGHT_BIT = 0;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic CTRL_EIGHT_RST = 1'b1;
    localparam logic [23:0] SIX_BIT_KEEP = 24'h3f3f3f;

    // ==========================================================
    // Sizes and output levels
    localparam int COLOR_BITS_DEF = 8;
    localparam int PAL_ENTRIES = 256;
    localparam int OVL_ENTRIES = 16;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int LVL_W = 10;
    localparam logic [LVL_W-1:0] SYNC_STEP = 10'h06e;
    localparam logic [LVL_W-1:0] SETUP_STEP = 10'h015;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] index;
        logic [3:0] ovl;
        logic sync_n;
        logic blank_n;
    } pix_s;

    typedef struct packed {
        logic [23:0] rgb;
        logic sync_n;
        logic blank_n;
    } vid_s;

endpackage : palette_pkg

// ===== logic/palette_pixel_lookup_port.sv
// Purpose: Pixel front end of a palette RAM-DAC with masked lookup and overlays
// Assumes: Frame buffer drives pixels on clk; pedestal strap is asynchronous
// Notes:   Output levels are digital codes for three current DACs
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns

// ==========================================================
// Buffer between lookup and DAC stage
module fifo_buf #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] READY_CNT = (AW+1)'(DEPTH - 2);

    initial
    begin
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
            $error("fifo depth must be a power of two, at least 4");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && cnt_q != FULL_CNT;
    assign pop = out_valid && out_ready;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rd_q];
    assign level = cnt_q;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
        end
    end

    // Ready keeps two spare slots so a word already in flight upstream always fits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            in_ready <= cnt_d <= READY_CNT;
            out_valid <= cnt_d != '0;
        end
    end
endmodule : fifo_buf

// ==========================================================
// Top level
module palette_pixel_lookup_port #(
    parameter int COLOR_BITS = palette_pkg::COLOR_BITS_DEF,
    parameter int FIFO_DEPTH = palette_pkg::FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pixel stream from frame buffer
    input wire logic pixel_valid_in,
    output logic pixel_ready,
    input wire logic [7:0] pixel_index_in,
    input wire logic [3:0] overlay_select_in,
    input wire logic sync_n_in,
    input wire logic blank_n_in,
    // Pedestal strap
    input wire logic pedestal_in,
    // DAC side
    input wire logic dac_ready_in,
    output logic dac_valid_q,
    output logic [palette_pkg::LVL_W-1:0] dac_red_q,
    output logic [palette_pkg::LVL_W-1:0] dac_green_q,
    output logic [palette_pkg::LVL_W-1:0] dac_blue_q
);
    import palette_pkg::*;

    initial
    begin
        if (COLOR_BITS != 6 && COLOR_BITS != 8)
            $error("color width must be 6 or 8");
    end

    // ==========================================================
    // Register file
    logic [7:0] mask_q;
    logic [8:0] addr_q;
    logic eight_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [23:0] pal_mem [PAL_ENTRIES];
    logic [23:0] ovl_mem [OVL_ENTRIES];
    logic ped_meta_q;
    logic ped_q;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic req;
    logic wr_acc;
    logic rd_acc;
    logic [23:0] cur_word;
    logic [23:0] wr_word;
    logic [23:0] keep;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_acc = req && wb_we_i;
    assign rd_acc = req && !wb_we_i;
    assign cur_word = addr_q[ADDR_OVL_BIT] ? ovl_mem[addr_q[3:0]] : pal_mem[addr_q[7:0]];
    assign keep = eight_q ? 24'hffffff : SIX_BIT_KEEP;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_comb
    begin
        for (int b = 0; b < 3; b++)
            wr_word[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : cur_word[b*8 +: 8];
        wr_word = wr_word & keep;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mask_q <= MASK_RST;
            eight_q <= CTRL_EIGHT_RST;
        end
        else if (wr_acc && wb_sel_i[0])
        begin
            if (wb_adr_i == REG_MASK)
                mask_q <= wb_dat_i[7:0];
            if (wb_adr_i == REG_CTRL)
                eight_q <= wb_dat_i[CTRL_EIGHT_BIT] && COLOR_BITS == 8;
        end
    end

    // Address steps after each data access; overlay space ignores the top nibble
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            addr_q <= ADDR_RST;
        else if (wr_acc && wb_adr_i == REG_ADDR)
        begin
            if (wb_sel_i[0])
                addr_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                addr_q[ADDR_OVL_BIT] <= wb_dat_i[ADDR_OVL_BIT];
        end
        else if (req && wb_adr_i == REG_DATA)
            addr_q[7:0] <= addr_q[7:0] + 8'h01;
    end

    // Same clock as the pixel path, so one edge commits the whole word
    always_ff @(posedge clk)
    begin
        if (wr_acc && wb_adr_i == REG_DATA)
        begin
            if (!addr_q[ADDR_OVL_BIT])
                pal_mem[addr_q[7:0]] <= wr_word;
            else if (addr_q[3:0] != 4'h0)
                ovl_mem[addr_q[3:0]] <= wr_word;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdat_q <= 32'h0;
        else if (rd_acc)
        begin
            unique case (wb_adr_i)
                REG_MASK: rdat_q <= {24'h0, mask_q};
                REG_ADDR: rdat_q <= {23'h0, addr_q};
                REG_DATA: rdat_q <= {8'h0, cur_word & keep};
                REG_CTRL: rdat_q <= {31'h0, eight_q};
                REG_STAT: rdat_q <= {27'h0, ped_q, 4'(fifo_level)};
                default: rdat_q <= 32'h0;
            endcase
        end
    end

    // Strap is asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ped_meta_q <= 1'b0;
            ped_q <= 1'b0;
        end
        else
        begin
            ped_meta_q <= pedestal_in;
            ped_q <= ped_meta_q;
        end
    end

    // ==========================================================
    // Input stage and lookup
    pix_s s1_q;
    logic s1_valid_q;
    logic take;
    logic [7:0] masked;
    vid_s look;
    vid_s fifo_out;
    logic fifo_out_valid;

    assign take = pixel_valid_in && pixel_ready;
    assign masked = s1_q.index & mask_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_valid_q <= 1'b0;
            s1_q <= '{index: 8'h00, ovl: 4'h0, sync_n: 1'b1, blank_n: 1'b0};
        end
        else
        begin
            s1_valid_q <= take;
            if (take)
                s1_q <= '{index: pixel_index_in, ovl: overlay_select_in,
                          sync_n: sync_n_in, blank_n: blank_n_in};
        end
    end

    always_comb
    begin
        if (s1_q.ovl != 4'h0)
            look.rgb = ovl_mem[s1_q.ovl];
        else
            look.rgb = pal_mem[masked];
        look.sync_n = s1_q.sync_n;
        look.blank_n = s1_q.blank_n;
    end

    fifo_buf #(.WIDTH($bits(vid_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(s1_valid_q),
        .in_ready(pixel_ready),
        .in_data(look),
        .out_valid(fifo_out_valid),
        .out_ready(dac_ready_in),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // ==========================================================
    // DAC level stage
    function automatic logic [LVL_W-1:0] level_of(input logic [7:0] c, input logic six,
                                                  input logic s_n, input logic b_n, input logic ped);
        logic [7:0] code;
        logic [LVL_W-1:0] lvl;
        code = six ? {c[5:0], c[5:4]} : c;
        lvl = s_n ? SYNC_STEP : '0;
        if (b_n)
            lvl = lvl + (ped ? SETUP_STEP : '0) + LVL_W'(code);
        return lvl;
    endfunction : level_of

    logic pop;

    assign pop = fifo_out_valid && dac_ready_in;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dac_valid_q <= 1'b0;
            dac_red_q <= '0;
            dac_green_q <= '0;
            dac_blue_q <= '0;
        end
        else if (dac_ready_in)
        begin
            dac_valid_q <= fifo_out_valid;
            if (pop)
            begin
                dac_red_q <= level_of(fifo_out.rgb[7:0], !eight_q, fifo_out.sync_n, fifo_out.blank_n, ped_q);
                dac_green_q <= level_of(fifo_out.rgb[15:8], !eight_q, fifo_out.sync_n, fifo_out.blank_n, ped_q);
                dac_blue_q <= level_of(fifo_out.rgb[23:16], !eight_q, fifo_out.sync_n, fifo_out.blank_n, ped_q);
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pop_blanked;
        pop && !fifo_out.blank_n;
    endsequence

    a_capture_aligned: assert property (take |=> s1_valid_q && s1_q.index == $past(pixel_index_in)
        && s1_q.sync_n == $past(sync_n_in) && s1_q.blank_n == $past(blank_n_in)) else $error("capture misaligned");
    a_palette_pick: assert property (s1_valid_q && s1_q.ovl == 4'h0
        |-> look.rgb == pal_mem[s1_q.index & mask_q]) else $error("palette lookup wrong");
    a_overlay_pick: assert property (s1_valid_q && s1_q.ovl != 4'h0
        |-> look.rgb == ovl_mem[s1_q.ovl]) else $error("overlay lookup wrong");
    a_push_room: assert property (s1_valid_q |-> fifo_level != 4'(FIFO_DEPTH)) else $error("push lost");
    a_blank_level: assert property (s_pop_blanked ##0 fifo_out.sync_n
        |=> dac_red_q == SYNC_STEP && dac_green_q == SYNC_STEP && dac_blue_q == SYNC_STEP) else $error("blank level");
    a_sync_level: assert property (s_pop_blanked ##0 !fifo_out.sync_n
        |=> dac_red_q == '0 && dac_green_q == '0 && dac_blue_q == '0) else $error("sync level");
    a_white_level: assert property (pop && fifo_out.blank_n && fifo_out.sync_n && eight_q
        && fifo_out.rgb == 24'hffffff |=> dac_red_q == SYNC_STEP + ($past(ped_q) ? SETUP_STEP : '0) + 10'h0ff)
        else $error("white level");
    a_black_setup: assert property (pop && fifo_out.blank_n && fifo_out.sync_n && fifo_out.rgb[7:0] == 8'h00
        |=> dac_red_q == SYNC_STEP + ($past(ped_q) ? SETUP_STEP : '0)) else $error("black setup");
    a_mask_write: assert property (wr_acc && wb_adr_i == REG_MASK && wb_sel_i[0]
        |=> mask_q == $past(wb_dat_i[7:0]) && ack_q) else $error("mask write lost");
    a_palette_write: assert property (wr_acc && wb_adr_i == REG_DATA && !addr_q[ADDR_OVL_BIT]
        && wb_sel_i[2:0] == 3'h7 && eight_q |=> pal_mem[$past(addr_q[7:0])] == $past(wb_dat_i[23:0]))
        else $error("palette write lost");
endmodule : palette_pixel_lookup_port

// ===== tb/frame_source.sv
// Purpose: Frame buffer model that feeds pixel words to the lookup port
// Assumes: A word is taken at an edge where valid and ready are both high
// Notes:   Idle lines toggle so a stale word can never look valid
`timescale 1ns/1ns

module frame_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pixel stream
    input wire logic pixel_ready,
    output logic pixel_valid_in,
    output logic [7:0] pixel_index_in,
    output logic [3:0] overlay_select_in,
    output logic sync_n_in,
    output logic blank_n_in
);
    import palette_pkg::*;

    pix_s words[$];
    pix_s cur = '0;
    int head = 0;

    // ==========================================================
    // Queue of words to send
    task automatic push(input pix_s w);
    begin
        words.push_back(w);
    end
    endtask : push

    // Sync and blank ride in the same word as their pixel
    assign {pixel_index_in, overlay_select_in, sync_n_in, blank_n_in} = cur;

    // ==========================================================
    // Presenter: holds each word until it is taken
    always @(posedge clk)
    begin
        if (pixel_valid_in && pixel_ready)
        begin
            head = head + 1;
        end
        if (rst_n && head < words.size())
        begin
            pixel_valid_in <= 1'b1;
            cur <= words[head];
        end
        else
        begin
            pixel_valid_in <= 1'b0;
            cur <= ~cur;
        end
    end
endmodule : frame_source

// ===== tb/palette_pixel_lookup_port_tb.sv
// Purpose: Self-checking bench for the palette pixel lookup port
// Assumes: One 50 MHz clock; host writes colors before pixels use them
// Notes:   Mask and strap are kept steady while pixels are in flight
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e) || $isunknown(g)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module palette_pixel_lookup_port_tb;
    import palette_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, pixel_valid_in, pixel_ready, sync_n_in, blank_n_in, dac_valid_q;
    logic [7:0] pixel_index_in;
    logic [3:0] overlay_select_in;
    logic pedestal_in = 1'b0;
    logic dac_ready_in = 1'b1;
    logic [LVL_W-1:0] dac_red_q, dac_green_q, dac_blue_q;
    logic [23:0] pal[256];
    logic [23:0] ovl_m[16];
    logic [7:0] mask_v = 8'hff;
    logic [3*LVL_W-1:0] exp_q[$];
    logic [3*LVL_W-1:0] e_v;
    int n_mismatch = 0;
    int checked = 0;

    initial forever #10 clk = ~clk;

    palette_pixel_lookup_port u_palette_pixel_lookup_port (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pixel_valid_in(pixel_valid_in), .pixel_ready(pixel_ready),
        .pixel_index_in(pixel_index_in), .overlay_select_in(overlay_select_in), .sync_n_in(sync_n_in),
        .blank_n_in(blank_n_in), .pedestal_in(pedestal_in), .dac_ready_in(dac_ready_in),
        .dac_valid_q(dac_valid_q), .dac_red_q(dac_red_q), .dac_green_q(dac_green_q), .dac_blue_q(dac_blue_q));

    frame_source u_frame_source (.clk(clk), .rst_n(rst_n), .pixel_ready(pixel_ready),
        .pixel_valid_in(pixel_valid_in), .pixel_index_in(pixel_index_in),
        .overlay_select_in(overlay_select_in), .sync_n_in(sync_n_in), .blank_n_in(blank_n_in));

    // ==========================================================
    // Helpers
    function automatic logic [LVL_W-1:0] lvl(input logic [7:0] c, input logic s, input logic b, input logic p);
        lvl = (s ? SYNC_STEP : 10'h000) + (b ? (p ? SETUP_STEP : 10'h000) + {2'b00, c} : 10'h000);
    endfunction : lvl

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("ack", 1'b1, wb_ack_o)
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        @(posedge clk);
    end
    endtask : wb

    task automatic put(input logic o, input logic [7:0] i, input logic [23:0] c);
    begin
        wb(1'b1, REG_ADDR, {23'h0, o, i});
        wb(1'b1, REG_DATA, {8'h00, c});
        if (o) ovl_m[i[3:0]] = c;
        else pal[i] = c;
    end
    endtask : put

    task automatic px(input logic [7:0] i, input logic [3:0] o, input logic s, input logic b);
        logic [23:0] c;
    begin
        c = (o != 4'h0) ? ovl_m[o] : pal[i & mask_v];
        exp_q.push_back({lvl(c[7:0], s, b, pedestal_in), lvl(c[15:8], s, b, pedestal_in),
            lvl(c[23:16], s, b, pedestal_in)});
        u_frame_source.push('{index: i, ovl: o, sync_n: s, blank_n: b});
    end
    endtask : px

    task automatic drain;
        int n;
    begin
        for (n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge clk);
        `CHK("drain", 0, exp_q.size())
    end
    endtask : drain

    // DAC monitor: every word that leaves must match the next expected one
    always @(posedge clk)
    begin
        if (rst_n && dac_valid_q === 1'b1 && dac_ready_in === 1'b1)
        begin
            e_v = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
            `CHK("dac", e_v, {dac_red_q, dac_green_q, dac_blue_q})
        end
    end

    // ==========================================================
    // Scenarios
    task automatic t_regs;
    begin
        wb(1'b0, REG_MASK, 32'h0);
        `CHK("mask rst", 32'h000000ff, rd)
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK("eight bit", 1'b1, rd[0])
        wb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    end
    endtask : t_regs

    task automatic t_palette;
    begin
        put(1'b0, 8'h00, 24'h000000);
        put(1'b0, 8'hff, 24'hffffff);
        put(1'b0, 8'h5a, 24'h563412);
        px(8'h00, 4'h0, 1'b1, 1'b1);
        px(8'hff, 4'h0, 1'b1, 1'b1);
        px(8'h5a, 4'h0, 1'b1, 1'b1);
        drain();
        wb(1'b1, REG_ADDR, 32'h0000005a);
        wb(1'b0, REG_DATA, 32'h0);
        `CHK("pal read", 32'h00563412, rd)
        wb(1'b0, REG_ADDR, 32'h0);
        `CHK("addr step", 32'h0000005b, rd)
    end
    endtask : t_palette

    task automatic t_mask;
    begin
        put(1'b0, 8'h0a, 24'h0c0b0a);
        wb(1'b1, REG_MASK, 32'h0000000f);
        mask_v = 8'h0f;
        wb(1'b0, REG_MASK, 32'h0);
        `CHK("mask", 32'h0000000f, rd)
        px(8'hfa, 4'h0, 1'b1, 1'b1);
        drain();
        wb(1'b1, REG_MASK, 32'h000000ff);
        mask_v = 8'hff;
    end
    endtask : t_mask

    task automatic t_overlay;
    begin
        put(1'b1, 8'h01, 24'h332211);
        put(1'b1, 8'h0f, 24'hc0b0a0);
        px(8'h5a, 4'h1, 1'b1, 1'b1);
        px(8'hff, 4'hf, 1'b1, 1'b1);
        drain();
    end
    endtask : t_overlay

    task automatic t_levels;
        int p, k;
    begin
        for (p = 0; p < 2; p++)
        begin
            pedestal_in <= p[0];
            repeat (6) @(posedge clk);
            wb(1'b0, REG_STAT, 32'h0);
            `CHK("strap", p[0], rd[4])
            for (k = 0; k < 4; k++) px(8'h5a, 4'h0, k[1], k[0]);
            drain();
        end
        pedestal_in <= 1'b0;
        repeat (6) @(posedge clk);
    end
    endtask : t_levels

    task automatic t_stall;
        int k;
    begin
        dac_ready_in <= 1'b0;
        for (k = 0; k < 12; k++) px(k[1] ? 8'hff : 8'h5a, {3'h0, k[0]}, k[0], k[1] | k[2]);
        repeat (30) @(posedge clk);
        `CHK("ready full", 1'b0, pixel_ready)
        dac_ready_in <= 1'b1;
        drain();
    end
    endtask : t_stall

    // ==========================================================
    // Run control
    task automatic summarize;
    begin
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask : summarize

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_palette();
        t_mask();
        t_overlay();
        t_levels();
        t_stall();
        summarize();
    end
endmodule : palette_pixel_lookup_port_tb
